// File: hw/flash_sr_pkg.sv
package flash_sr_pkg;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int WRSR_TIME_US = 15;
  localparam int PROG_TIME_US = 3;
  localparam int ERASE_TIME_US = 400;
  localparam int CHIP_TIME_US = 100000;
  localparam int WRSR_CYCLES = WRSR_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // status word bit positions
  localparam int S_BUSY = 0;
  localparam int S_WEL = 1;
  localparam int S_RANGE_LO = 2;
  localparam int S_TB = 6;
  localparam int S_HWP = 7;
  localparam int S_PLOCK = 8;
  localparam int S_QUAD = 9;
  localparam int S_CMP = 14;
  localparam int S_SUSP = 15;
  localparam int S_ADS = 16;
  localparam int S_WPS = 18;

  // array geometry
  localparam logic [10:0] BLOCK_COUNT = 11'h400;
  localparam logic [3:0] RANGE_ALL = 4'hb;

  // instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_WREXT = 8'hc5;
  localparam logic [7:0] OP_RDEXT = 8'hc8;
  localparam logic [7:0] OP_EN4B = 8'hb7;
  localparam logic [7:0] OP_EX4B = 8'he9;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE = 8'hd8;
  localparam logic [7:0] OP_CE = 8'hc7;
  localparam logic [7:0] OP_SECER = 8'h44;
  localparam logic [7:0] OP_SECPR = 8'h42;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_PREFIX1 = 8'haa;
  localparam logic [7:0] OP_PREFIX2 = 8'h55;

  typedef enum logic [1:0] {
    OPK_PROG = 2'b00,
    OPK_ERASE = 2'b01,
    OPK_CHIP = 2'b10,
    OPK_SECURITY = 2'b11
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_BODY = 2'b01,
    ST_READ = 2'b11,
    ST_DROP = 2'b10
  } frame_state_t;

  typedef struct packed {
    logic [3:0] protect_range_field;
    logic top_bottom_select;
    logic complement_protect;
    logic protect_scheme_select;
  } protect_cfg_t;

  localparam protect_cfg_t PROTECT_RST = '{4'h0, 1'b0, 1'b0, 1'b0};
  localparam logic [7:0] EXT_RST = 8'h00;

  // range, side and complement applied to one array address
  function automatic logic range_hit(protect_cfg_t c, logic [31:0] a);
    logic [10:0] blk;
    logic [10:0] size;
    logic hit;
    blk = {1'b0, a[25:16]};
    if (c.protect_range_field == 4'h0)
      size = 11'h000;
    else if (c.protect_range_field >= RANGE_ALL)
      size = BLOCK_COUNT;
    else
      size = 11'h001 << (c.protect_range_field - 4'h1);
    if (c.top_bottom_select)
      hit = blk < size;
    else
      hit = blk >= (BLOCK_COUNT - size);
    return hit ^ c.complement_protect;
  endfunction

endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '1;
      pin_sync_out <= '1;
    end
    else
    begin
      meta_r <= pin_in;
      pin_sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hw/spi_byte_shift.sv
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shift (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial side, already synchronised
  input wire logic frame_active,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic mosi_bit,
  output logic miso_bit,
  // byte side
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic hold_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!frame_active)
        bit_cnt_r <= 3'h0;
      else if (sclk_rise)
      begin
        rx_sh_r <= {rx_sh_r[5:0], mosi_bit};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          rx_byte <= {rx_sh_r, mosi_bit};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // msb stands through the first falling edge after a load
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_sh_r <= 8'h00;
      hold_r <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_sh_r <= tx_byte;
      hold_r <= 1'b1;
    end
    else if (sclk_fall && frame_active)
    begin
      if (hold_r)
        hold_r <= 1'b0;
      else
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  assign miso_bit = tx_sh_r[7];
endmodule
`default_nettype wire

// File: hw/flash_status_write_protect.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_write_protect #(
  parameter int unsigned ERASE_CYCLES =
    flash_sr_pkg::ERASE_TIME_US * flash_sr_pkg::CLK_MHZ,
  parameter int unsigned CHIP_CYCLES =
    flash_sr_pkg::CHIP_TIME_US * flash_sr_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic write_protect_n,
  output logic miso,
  output logic miso_oe,
  // per-block lock answer for target_addr
  input wire logic block_lock_hit,
  // array operation issue
  output logic op_start,
  output flash_sr_pkg::op_kind_t op_kind,
  output logic [31:0] target_addr,
  // status and configuration
  output logic busy,
  output logic suspended,
  output logic write_enable_latch,
  output flash_sr_pkg::protect_cfg_t protect_cfg,
  output logic hardware_protect_bit,
  output logic power_lock_bit,
  output logic otp_locked,
  output logic quad_enable,
  output logic current_address_mode_flag,
  output logic [7:0] ext_addr
);
  logic [3:0] pins_s;
  logic cs_s, sclk_s, mosi_s, wp_s;
  logic sclk_q, cs_q;
  logic sclk_rise, sclk_fall, cs_rise, frame_active;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_load;
  logic [7:0] tx_byte;
  flash_sr_pkg::frame_state_t state_r;
  logic [7:0] opcode_r;
  logic [2:0] nbytes_r;
  logic [7:0] wdata_r;
  logic [31:0] addr_sh_r;
  logic [1:0] prefix_r;
  logic [31:0] cnt_r;
  logic [23:0] status_word;
  logic [7:0] op_now;
  logic [2:0] alen;
  logic wr_ok, is_wrsr, wrsr_go, op_go, op_prot;
  logic ex_end;
  flash_sr_pkg::op_kind_t kind_nxt;
  logic [31:0] cycles_nxt;

  pin_sync #(.W(4)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({cs_n, sclk, mosi, write_protect_n}),
    .pin_sync_out(pins_s)
  );

  assign {cs_s, sclk_s, mosi_s, wp_s} = pins_s;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q <= cs_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;
  assign cs_rise = cs_s & ~cs_q;
  assign frame_active = ~cs_s;

  spi_byte_shift u_shift (
    .clk(clk),
    .reset_n(reset_n),
    .frame_active(frame_active),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .mosi_bit(mosi_s),
    .miso_bit(miso),
    .tx_load(tx_load),
    .tx_byte(tx_byte),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  always_comb
  begin
    status_word = 24'h00_0000;
    status_word[flash_sr_pkg::S_BUSY] = busy;
    status_word[flash_sr_pkg::S_WEL] = write_enable_latch;
    status_word[flash_sr_pkg::S_RANGE_LO +: 4] =
      protect_cfg.protect_range_field;
    status_word[flash_sr_pkg::S_TB] = protect_cfg.top_bottom_select;
    status_word[flash_sr_pkg::S_HWP] = hardware_protect_bit;
    status_word[flash_sr_pkg::S_PLOCK] = power_lock_bit;
    status_word[flash_sr_pkg::S_QUAD] = quad_enable;
    status_word[flash_sr_pkg::S_CMP] = protect_cfg.complement_protect;
    status_word[flash_sr_pkg::S_SUSP] = suspended;
    status_word[flash_sr_pkg::S_ADS] = current_address_mode_flag;
    status_word[flash_sr_pkg::S_WPS] = protect_cfg.protect_scheme_select;
  end

  // read data, refreshed each byte of a read frame
  assign op_now = (state_r == flash_sr_pkg::ST_OPCODE) ? rx_byte : opcode_r;
  always_comb
  begin
    case (op_now)
      flash_sr_pkg::OP_RDSR1: tx_byte = status_word[7:0];
      flash_sr_pkg::OP_RDSR2: tx_byte = status_word[15:8];
      flash_sr_pkg::OP_RDSR3: tx_byte = status_word[23:16];
      flash_sr_pkg::OP_RDEXT: tx_byte = ext_addr;
      default: tx_byte = 8'h00;
    endcase
  end
  assign tx_load = rx_valid && (state_r != flash_sr_pkg::ST_DROP) &&
    ((state_r == flash_sr_pkg::ST_READ) || (tx_byte != 8'h00) ||
     (op_now == flash_sr_pkg::OP_RDSR1) || (op_now == flash_sr_pkg::OP_RDSR2)
     || (op_now == flash_sr_pkg::OP_RDSR3)
     || (op_now == flash_sr_pkg::OP_RDEXT));

  // frame sequencing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= flash_sr_pkg::ST_OPCODE;
      opcode_r <= 8'h00;
      nbytes_r <= 3'h0;
      wdata_r <= 8'h00;
      addr_sh_r <= 32'h0000_0000;
    end
    else if (cs_rise)
    begin
      state_r <= flash_sr_pkg::ST_OPCODE;
      nbytes_r <= 3'h0;
    end
    else if (rx_valid)
    begin
      if (nbytes_r != 3'h7)
        nbytes_r <= nbytes_r + 3'h1;
      if (nbytes_r == 3'h1)
        wdata_r <= rx_byte;
      if (nbytes_r != 3'h0 && state_r == flash_sr_pkg::ST_BODY)
        addr_sh_r <= {addr_sh_r[23:0], rx_byte};
      if (state_r == flash_sr_pkg::ST_OPCODE)
      begin
        opcode_r <= rx_byte;
        if (busy && rx_byte != flash_sr_pkg::OP_RDSR1 &&
            rx_byte != flash_sr_pkg::OP_RDSR2 &&
            rx_byte != flash_sr_pkg::OP_RDSR3 &&
            rx_byte != flash_sr_pkg::OP_SUSP)
          state_r <= flash_sr_pkg::ST_DROP;
        else if (tx_load)
          state_r <= flash_sr_pkg::ST_READ;
        else
          state_r <= flash_sr_pkg::ST_BODY;
      end
    end
  end

  // decisions taken at frame end
  assign ex_end = cs_rise && (state_r != flash_sr_pkg::ST_DROP);
  assign is_wrsr = (opcode_r == flash_sr_pkg::OP_WRSR1) ||
    (opcode_r == flash_sr_pkg::OP_WRSR2) ||
    (opcode_r == flash_sr_pkg::OP_WRSR3);
  assign wr_ok = write_enable_latch && !power_lock_bit && !otp_locked &&
    !(hardware_protect_bit && !quad_enable && !wp_s);
  assign wrsr_go = ex_end && is_wrsr && nbytes_r == 3'h2 && wr_ok;
  assign alen = current_address_mode_flag ? 3'h4 : 3'h3;

  always_comb
  begin
    kind_nxt = flash_sr_pkg::OPK_PROG;
    cycles_nxt = 32'(flash_sr_pkg::PROG_CYCLES);
    op_go = 1'b0;
    case (opcode_r)
      flash_sr_pkg::OP_PP, flash_sr_pkg::OP_QPP:
        op_go = nbytes_r > alen + 3'h1;
      flash_sr_pkg::OP_SE, flash_sr_pkg::OP_BE:
      begin
        kind_nxt = flash_sr_pkg::OPK_ERASE;
        cycles_nxt = 32'(ERASE_CYCLES);
        op_go = nbytes_r == alen + 3'h1;
      end
      flash_sr_pkg::OP_CE:
      begin
        kind_nxt = flash_sr_pkg::OPK_CHIP;
        cycles_nxt = 32'(CHIP_CYCLES);
        op_go = nbytes_r == 3'h1;
      end
      flash_sr_pkg::OP_SECER, flash_sr_pkg::OP_SECPR:
      begin
        kind_nxt = flash_sr_pkg::OPK_SECURITY;
        op_go = nbytes_r >= alen + 3'h1;
      end
      default: op_go = 1'b0;
    endcase
  end

  // scheme select picks range bits or per-block locks
  assign op_prot = (kind_nxt == flash_sr_pkg::OPK_SECURITY) ? 1'b0 :
    protect_cfg.protect_scheme_select ? block_lock_hit :
    (kind_nxt == flash_sr_pkg::OPK_CHIP) ?
      (protect_cfg.protect_range_field != 4'h0 ||
       protect_cfg.complement_protect) :
    flash_sr_pkg::range_hit(protect_cfg, target_addr);

  // target address follows the address bytes as they arrive
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      target_addr <= 32'h0000_0000;
    else if (current_address_mode_flag)
      target_addr <= addr_sh_r;
    else
      target_addr <= {ext_addr, addr_sh_r[23:0]};
  end

  // array operation issue
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_start <= 1'b0;
      op_kind <= flash_sr_pkg::OPK_PROG;
    end
    else
    begin
      op_start <= ex_end && op_go && write_enable_latch && !op_prot;
      if (ex_end && op_go)
        op_kind <= kind_nxt;
    end
  end

  // busy, countdown and suspend
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      suspended <= 1'b0;
      cnt_r <= 32'h0000_0000;
    end
    else if (wrsr_go)
    begin
      busy <= 1'b1;
      cnt_r <= 32'(flash_sr_pkg::WRSR_CYCLES);
    end
    else if (ex_end && op_go && write_enable_latch && !op_prot)
    begin
      busy <= 1'b1;
      cnt_r <= cycles_nxt;
    end
    else if (ex_end && opcode_r == flash_sr_pkg::OP_SUSP && busy)
    begin
      busy <= 1'b0;
      suspended <= 1'b1;
    end
    else if (ex_end && opcode_r == flash_sr_pkg::OP_RESUME && suspended)
    begin
      busy <= 1'b1;
      suspended <= 1'b0;
    end
    else if (busy)
    begin
      cnt_r <= cnt_r - 32'h0000_0001;
      if (cnt_r <= 32'h0000_0001)
        busy <= 1'b0;
    end
  end

  // write enable latch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      write_enable_latch <= 1'b0;
    else if (ex_end && opcode_r == flash_sr_pkg::OP_WREN && nbytes_r == 3'h1)
      write_enable_latch <= 1'b1;
    else if (wrsr_go ||
             (ex_end && opcode_r == flash_sr_pkg::OP_WRDI) ||
             (ex_end && op_go && !op_prot))
      write_enable_latch <= 1'b0;
  end

  // prefix tracking for the permanent lock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prefix_r <= 2'h0;
    else if (ex_end)
    begin
      if (opcode_r == flash_sr_pkg::OP_PREFIX1 && nbytes_r == 3'h1)
        prefix_r <= 2'h1;
      else if (opcode_r == flash_sr_pkg::OP_PREFIX2 && prefix_r == 2'h1)
        prefix_r <= 2'h2;
      else if (opcode_r != flash_sr_pkg::OP_WREN)
        prefix_r <= 2'h0;
    end
  end

  // status and configuration bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      protect_cfg <= flash_sr_pkg::PROTECT_RST;
      hardware_protect_bit <= 1'b0;
      power_lock_bit <= 1'b0;
      otp_locked <= 1'b0;
      quad_enable <= 1'b0;
    end
    else if (wrsr_go)
    begin
      case (opcode_r)
        flash_sr_pkg::OP_WRSR1:
        begin
          protect_cfg.protect_range_field <= wdata_r[5:2];
          protect_cfg.top_bottom_select <= wdata_r[6];
          hardware_protect_bit <= wdata_r[7];
        end
        flash_sr_pkg::OP_WRSR2:
        begin
          power_lock_bit <= wdata_r[0];
          quad_enable <= wdata_r[1];
          protect_cfg.complement_protect <= wdata_r[6];
          if (prefix_r == 2'h2 && wdata_r[0])
            otp_locked <= 1'b1;
        end
        default:
          protect_cfg.protect_scheme_select <= wdata_r[2];
      endcase
    end
  end

  // address mode and extended address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      current_address_mode_flag <= 1'b0;
      ext_addr <= flash_sr_pkg::EXT_RST;
    end
    else if (ex_end)
    begin
      if (opcode_r == flash_sr_pkg::OP_EN4B)
        current_address_mode_flag <= 1'b1;
      else if (opcode_r == flash_sr_pkg::OP_EX4B)
        current_address_mode_flag <= 1'b0;
      else if (opcode_r == flash_sr_pkg::OP_WREXT && nbytes_r == 3'h2)
        ext_addr <= wdata_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      miso_oe <= 1'b0;
    else if (cs_s)
      miso_oe <= 1'b0;
    else if (tx_load)
      miso_oe <= 1'b1;
  end

  a_busy_on_start: assert property (@(posedge clk) disable iff (!reset_n)
    op_start |-> busy && !write_enable_latch)
    else $error("operation issued without busy or with latch set");
  a_busy_drops_cmd: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && state_r == flash_sr_pkg::ST_OPCODE && busy &&
    rx_byte == flash_sr_pkg::OP_WREN |=> state_r == flash_sr_pkg::ST_DROP)
    else $error("instruction taken while busy");
  a_busy_ends: assert property (@(posedge clk) disable iff (!reset_n)
    busy && cnt_r == 32'h0000_0001 && !cs_rise |=> !busy)
    else $error("busy did not clear at end of count");
  a_wel_sets: assert property (@(posedge clk) disable iff (!reset_n)
    ex_end && opcode_r == flash_sr_pkg::OP_WREN && nbytes_r == 3'h1
    |=> write_enable_latch)
    else $error("write enable did not set latch");
  a_wp_refuses: assert property (@(posedge clk) disable iff (!reset_n)
    cs_rise && is_wrsr && hardware_protect_bit && !quad_enable && !wp_s
    && !busy |=> $stable(protect_cfg) && !busy)
    else $error("status written while protect pin low");
  a_wrsr_accept: assert property (@(posedge clk) disable iff (!reset_n)
    ex_end && is_wrsr && nbytes_r == 3'h2 && write_enable_latch &&
    !power_lock_bit && !otp_locked && (!hardware_protect_bit || wp_s)
    |=> busy ##0 !write_enable_latch)
    else $error("permitted status write not taken");
  a_plock_holds: assert property (@(posedge clk) disable iff (!reset_n)
    power_lock_bit |=> $stable(protect_cfg) && power_lock_bit)
    else $error("status changed under power lock");
  a_otp_holds: assert property (@(posedge clk) disable iff (!reset_n)
    otp_locked |=> otp_locked && $stable(hardware_protect_bit))
    else $error("status changed under permanent lock");
  a_ext_addr: assert property (@(posedge clk) disable iff (!reset_n)
    op_start && !current_address_mode_flag
    |-> target_addr[31:24] == ext_addr)
    else $error("top address byte not from extended register");
endmodule
`default_nettype wire

// File: verification/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // one instruction a frame, msb first, mode 0, 80 ns serial period
  task automatic frame(input int nb, input logic [39:0] tx,
    output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < nb * 8; i++)
    begin
      mosi <= tx[39 - i];
      repeat (10) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[6:0], miso};
      repeat (10) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (10) @(posedge clk);
    cs_n <= 1'b1;
    // released line must not keep showing the last bit
    mosi <= ~mosi;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verification/flash_status_write_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module flash_status_write_protect_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_protect_n = 1'b1;
  logic block_lock_hit = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe, op_start, busy, suspended;
  logic write_enable_latch, hardware_protect_bit, power_lock_bit;
  logic otp_locked, quad_enable, current_address_mode_flag;
  logic [7:0] ext_addr, rx, s, d;
  logic [31:0] target_addr;
  flash_sr_pkg::op_kind_t op_kind;
  flash_sr_pkg::protect_cfg_t protect_cfg;
  logic [3:0] rng_m;
  logic tb_m, hwp_m, ok, wp;
  int mismatches = 0;
  int checked = 0;
  int starts = 0;
  int oe_seen = 0;

  always #2 clk = ~clk;

  always @(posedge clk)
    if (op_start === 1'b1)
      starts++;

  always @(posedge clk)
    if (miso_oe === 1'b1)
      oe_seen++;

  flash_status_write_protect #(.ERASE_CYCLES(500), .CHIP_CYCLES(50))
    i_flash_status_write_protect (.clk, .reset_n, .cs_n, .sclk, .mosi,
    .write_protect_n, .miso, .miso_oe, .block_lock_hit, .op_start,
    .op_kind, .target_addr, .busy, .suspended, .write_enable_latch,
    .protect_cfg, .hardware_protect_bit, .power_lock_bit, .otp_locked,
    .quad_enable, .current_address_mode_flag, .ext_addr);

  spi_host_model i_spi_host_model (.clk, .cs_n, .sclk, .mosi, .miso);

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // status write admitted with both locks clear and latch set, unless protect bit set, pin low and quad off
  function automatic logic wr_ok(input logic hwp, input logic wpn,
    input logic quad);
    return !hwp || wpn || quad;
  endfunction

  task automatic host(input int nb, input logic [39:0] tx);
    i_spi_host_model.frame(nb, tx, rx);
  endtask

  task automatic wsr(input logic [7:0] op, input logic [7:0] v);
    host(1, {flash_sr_pkg::OP_WREN, 32'h0000_0000});
    host(2, {op, v, 24'h00_0000});
  endtask

  // four-byte-mode erase that must start or be refused
  task automatic erase4(input logic [31:0] a, input logic go);
    int n0;
    n0 = starts;
    host(1, {flash_sr_pkg::OP_WREN, 32'h0000_0000});
    host(5, {flash_sr_pkg::OP_SE, a});
    `CHK("start", go, starts != n0)
    `CHK("busy", go, busy)
    `CHK("wel", !go, write_enable_latch)
    wait_idle();
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // nothing else is sent until busy drops
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic pwr();
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    s = 8'h12;
    rng_m = 4'h0;
    tb_m = 1'b0;
    hwp_m = 1'b0;
    pwr();
    `CHK("cfg", 7'h00, protect_cfg)
    `CHK("wel", 1'b0, write_enable_latch)
    `CHK("ads", 1'b0, current_address_mode_flag)
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      s = lfsr(s);
      d = {(k == 0) | s[7], s[6:2], 2'b00};
      wp = (k == 2) | ((k != 1) & s[1]);
      write_protect_n <= wp;
      ok = wr_ok(hwp_m, wp, 1'b0);
      wsr(flash_sr_pkg::OP_WRSR1, d);
      `CHK("busy", ok, busy)
      `CHK("wel", !ok, write_enable_latch)
      if (ok)
        host(1, {flash_sr_pkg::OP_WREN, 32'h0000_0000});
      wait_idle();
      `CHK("idle wel", !ok, write_enable_latch)
      if (ok)
      begin
        rng_m = d[5:2];
        tb_m = d[6];
        hwp_m = d[7];
      end
      `CHK("range", rng_m, protect_cfg.protect_range_field)
      `CHK("tb", tb_m, protect_cfg.top_bottom_select)
      `CHK("hwp", hwp_m, hardware_protect_bit)
    end
    `CHK("oe idle", 0, oe_seen)
    host(2, {flash_sr_pkg::OP_RDSR1, 32'h0000_0000});
    `CHK("sr1", {hwp_m, tb_m, rng_m, !ok, 1'b0}, rx)
    `CHK("oe", 1'b1, oe_seen > 0)
    `CHK("oe", 1'b0, miso_oe)
    $display("test random writes done");
    write_protect_n <= 1'b1;
    host(1, {flash_sr_pkg::OP_WRDI, 32'h0000_0000});
    `CHK("wel", 1'b0, write_enable_latch)
    host(2, {flash_sr_pkg::OP_WRSR1, ~d, 24'h00_0000});
    `CHK("busy", 1'b0, busy)
    `CHK("range", rng_m, protect_cfg.protect_range_field)
    wsr(flash_sr_pkg::OP_WRSR1, 8'h80);
    wait_idle();
    wsr(flash_sr_pkg::OP_WRSR2, 8'h42);
    wait_idle();
    `CHK("quad", 1'b1, quad_enable)
    `CHK("cmp", 1'b1, protect_cfg.complement_protect)
    write_protect_n <= 1'b0;
    wsr(flash_sr_pkg::OP_WRSR3, 8'h04);
    `CHK("busy", 1'b1, busy)
    wait_idle();
    `CHK("scheme", 1'b1, protect_cfg.protect_scheme_select)
    $display("test latch and quad done");
    wsr(flash_sr_pkg::OP_WRSR2, 8'h43);
    wait_idle();
    `CHK("plock", 1'b1, power_lock_bit)
    wsr(flash_sr_pkg::OP_WRSR1, 8'h00);
    `CHK("busy", 1'b0, busy)
    `CHK("hwp", 1'b1, hardware_protect_bit)
    pwr();
    `CHK("plock", 1'b0, power_lock_bit)
    host(1, {flash_sr_pkg::OP_PREFIX1, 32'h0000_0000});
    host(1, {flash_sr_pkg::OP_PREFIX2, 32'h0000_0000});
    wsr(flash_sr_pkg::OP_WRSR2, 8'h01);
    wait_idle();
    `CHK("otp", 1'b1, otp_locked)
    wsr(flash_sr_pkg::OP_WRSR1, 8'h3c);
    `CHK("busy", 1'b0, busy)
    $display("test locks done");
    pwr();
    s = lfsr(s);
    host(2, {flash_sr_pkg::OP_WREXT, s, 24'h00_0000});
    `CHK("ext", s, ext_addr)
    host(1, {flash_sr_pkg::OP_WREN, 32'h0000_0000});
    host(4, {flash_sr_pkg::OP_SE, 8'h01, s, 8'h00, 8'h00});
    `CHK("starts", 1, starts)
    `CHK("addr", {s, 8'h01, s, 8'h00}, target_addr)
    `CHK("kind", flash_sr_pkg::OPK_ERASE, op_kind)
    `CHK("busy", 1'b1, busy)
    `CHK("wel", 1'b0, write_enable_latch)
    host(1, {flash_sr_pkg::OP_SUSP, 32'h0000_0000});
    `CHK("susp", 1'b1, suspended)
    `CHK("busy", 1'b0, busy)
    host(1, {flash_sr_pkg::OP_RESUME, 32'h0000_0000});
    `CHK("susp", 1'b0, suspended)
    `CHK("busy", 1'b1, busy)
    wait_idle();
    `CHK("busy", 1'b0, busy)
    host(1, {flash_sr_pkg::OP_EN4B, 32'h0000_0000});
    `CHK("ads", 1'b1, current_address_mode_flag)
    $display("test address done");
    wsr(flash_sr_pkg::OP_WRSR1, 8'h04);
    wait_idle();
    erase4(32'h03ff_0000, 1'b0);
    erase4(32'h0000_0000, 1'b1);
    wsr(flash_sr_pkg::OP_WRSR2, 8'h40);
    wait_idle();
    erase4(32'h0000_0000, 1'b0);
    erase4(32'h03ff_0000, 1'b1);
    wsr(flash_sr_pkg::OP_WRSR3, 8'h04);
    wait_idle();
    block_lock_hit <= 1'b1;
    erase4(32'h0000_0000, 1'b0);
    block_lock_hit <= 1'b0;
    erase4(32'h0000_0000, 1'b1);
    $display("test protection done");
    print_verdict();
  end
endmodule
`default_nettype wire
